// ---- rtl/adp_pkg.sv ----
// shared constants and types for the converter pin-control link
package adp_pkg;
	// device side register addresses
	localparam logic [5:0] ADP_COMM_ADDR = 6'h00;
	localparam logic [5:0] ADP_IO_ADDR = 6'h01;
	localparam int ADP_RW_BIT = 6;
	localparam int ADP_BYTE_BITS = 8;
	// io port register fields
	localparam int ADP_IO_PA_BIT = 7;
	localparam int ADP_IO_PB_BIT = 6;
	localparam int ADP_IO_DIRA_BIT = 5;
	localparam int ADP_IO_DIRB_BIT = 4;
	localparam int ADP_IO_RDY_BIT = 3;
	localparam int ADP_IO_SYNC_BIT = 0;
	localparam logic [7:0] ADP_IO_RST = 8'h30;
	localparam logic [7:0] ADP_IO_WMASK = 8'hf9;
	// pin controls carried to the master clock side
	localparam logic [4:0] ADP_CTL_RST = 5'h06;
	// host register map
	localparam int ADP_AXI_AW = 8;
	localparam logic [7:0] ADP_CMD_OFS = 8'h00;
	localparam logic [7:0] ADP_STAT_OFS = 8'h04;
	localparam logic [7:0] ADP_CFG_OFS = 8'h08;
	localparam int ADP_CMD_RW_BIT = 6;
	localparam int ADP_CMD_WD_LSB = 8;
	localparam int ADP_STAT_BUSY_BIT = 0;
	localparam int ADP_STAT_DONE_BIT = 1;
	localparam int ADP_STAT_RD_LSB = 8;
	localparam int ADP_CFG_FRAMED_BIT = 0;
	localparam int ADP_CFG_RST_BIT = 1;
	localparam logic [1:0] ADP_CFG_RST = 2'h3;
	localparam logic [1:0] ADP_RESP_OKAY = 2'h0;
	localparam logic [1:0] ADP_RESP_SLVERR = 2'h2;
	// timing: half period in host clock cycles, reset tail in serial clock periods
	localparam int ADP_SCLK_HALF = 2;
	localparam logic [1:0] ADP_RST_TAIL = 2'h3;
	typedef enum logic [4:0] {
		ADP_IDLE = 5'b00001,
		ADP_SEL = 5'b00010,
		ADP_LOW = 5'b00100,
		ADP_HIGH = 5'b01000,
		ADP_GAP = 5'b10000
	} adp_hst_t;
endpackage : adp_pkg

// ---- rtl/adp_link_if.sv ----
// serial link between host controller and converter pins
`timescale 1ns/1ps
interface adp_link_if;
	logic sclk;
	logic cs_n_o;
	logic cs_n_oe;
	logic cs_n;
	logic din;
	logic dout;
	logic rst_pin_n;
	// internal pull-up keeps the device deselected
	assign cs_n = cs_n_oe ? cs_n_o : 1'b1;
	modport host (
		output sclk,
		output cs_n_o,
		output cs_n_oe,
		output din,
		output rst_pin_n,
		input dout
	);
	modport dev (
		input sclk,
		input cs_n,
		input din,
		input rst_pin_n,
		output dout
	);
endinterface : adp_link_if

// ---- rtl/adp_dev.sv ----
// converter digital pin control: serial port, io port, clock out
`timescale 1ns/1ps
module adp_dev
	import adp_pkg::*;
(
	input wire logic aclk,
	input wire logic mclk_out_en,
	output logic master_clock_inverted_output,
	adp_link_if.dev link,
	input wire logic gpio_pin_a_i,
	output logic gpio_pin_a_o,
	output logic gpio_pin_a_oe,
	input wire logic align_or_gpio_b_pin_i,
	output logic align_or_gpio_b_pin_o,
	output logic align_or_gpio_b_pin_oe,
	output logic align_pulse
);

	// serial clock domain state
	typedef struct packed {
		logic rs1;
		logic rs2;
		logic a1;
		logic a2;
		logic b1;
		logic b2;
		logic [2:0] cnt;
		logic data_ph;
		logic rd;
		logic [5:0] addr;
		logic [6:0] sh_in;
		logic [7:0] sh_out;
		logic [7:0] io;
	} adp_ser_t;

	// master clock domain state
	typedef struct packed {
		logic r1;
		logic r2;
		logic [4:0] c1;
		logic [4:0] c2;
		logic p1;
		logic p2;
		logic p3;
		logic pulse;
	} adp_mck_t;

	adp_ser_t s_q;
	adp_ser_t s_d;
	adp_mck_t m_q;
	adp_mck_t m_d;
	logic [7:0] rx;

	// io port readback
	function automatic logic [7:0] adp_io_read(
		input logic [7:0] io,
		input logic pin_a,
		input logic pin_b
	);
		logic [7:0] r;
		r = io;
		// input pins show the sampled level, outputs the latch
		r[ADP_IO_PA_BIT] = io[ADP_IO_DIRA_BIT] ? pin_a : io[ADP_IO_PA_BIT];
		r[ADP_IO_PB_BIT] = io[ADP_IO_DIRB_BIT] ? pin_b : io[ADP_IO_PB_BIT];
		r[2:1] = 2'h0;
		return r;
	endfunction : adp_io_read

	// register read by address
	function automatic logic [7:0] adp_reg_read(
		input logic [5:0] addr,
		input logic [7:0] io,
		input logic pin_a,
		input logic pin_b
	);
		logic [7:0] r;
		r = 8'h00;
		if (addr == ADP_IO_ADDR)
		begin
			r = adp_io_read(io, pin_a, pin_b);
		end
		return r;
	endfunction : adp_reg_read

	// serial shifter, clocked only by the serial clock
	always_comb
	begin
		s_d = s_q;
		s_d.rs1 = link.rst_pin_n;
		s_d.rs2 = s_q.rs1;
		// pins tied by the board when inputs
		s_d.a1 = gpio_pin_a_i;
		s_d.a2 = s_q.a1;
		s_d.b1 = align_or_gpio_b_pin_i;
		s_d.b2 = s_q.b1;
		rx = {s_q.sh_in, link.din};
		if (!s_q.rs2)
		begin
			// back to power-on state
			s_d.cnt = 3'h0;
			s_d.data_ph = 1'b0;
			s_d.rd = 1'b0;
			s_d.addr = ADP_COMM_ADDR;
			s_d.sh_in = 7'h00;
			s_d.sh_out = 8'h00;
			s_d.io = ADP_IO_RST;
		end
		else if (link.cs_n)
		begin
			// deselected: byte boundary, phase kept
			s_d.cnt = 3'h0;
		end
		else
		begin
			// select low: shift on each serial clock rise
			s_d.sh_in = rx[6:0];
			s_d.sh_out = {s_q.sh_out[6:0], 1'b0};
			s_d.cnt = s_q.cnt + 3'h1;
			if (s_q.cnt == 3'(ADP_BYTE_BITS - 1))
			begin
				if (!s_q.data_ph)
				begin
					// communications byte picks the target
					s_d.rd = rx[ADP_RW_BIT];
					s_d.addr = rx[5:0];
					s_d.data_ph = 1'b1;
					if (rx[ADP_RW_BIT])
					begin
						s_d.sh_out = adp_reg_read(rx[5:0], s_q.io,
							s_q.a2, s_q.b2);
					end
				end
				else
				begin
					s_d.data_ph = 1'b0;
					if (!s_q.rd && s_q.addr == ADP_IO_ADDR)
					begin
						s_d.io = rx & ADP_IO_WMASK;
					end
				end
			end
		end
	end

	always_ff @(posedge link.sclk)
	begin
		s_q <= s_d;
	end

	assign link.dout = s_q.sh_out[7];

	// pin drivers and align detect on the master clock
	always_comb
	begin
		m_d = m_q;
		m_d.r1 = link.rst_pin_n;
		m_d.r2 = m_q.r1;
		// quasi-static controls crossing as levels
		m_d.c1 = {s_q.io[ADP_IO_PA_BIT], s_q.io[ADP_IO_PB_BIT],
			s_q.io[ADP_IO_DIRA_BIT], s_q.io[ADP_IO_DIRB_BIT],
			s_q.io[ADP_IO_SYNC_BIT]};
		m_d.c2 = m_q.c1;
		m_d.p1 = align_or_gpio_b_pin_i;
		m_d.p2 = m_q.p1;
		m_d.p3 = m_q.p2;
		// falling edge on pin b restarts modulator and filter
		m_d.pulse = m_q.c2[0] & m_q.p3 & ~m_q.p2;
		if (!m_q.r2)
		begin
			m_d.c1 = ADP_CTL_RST;
			m_d.c2 = ADP_CTL_RST;
			m_d.pulse = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		m_q <= m_d;
	end

	// direction bit 1 means input
	assign gpio_pin_a_o = m_q.c2[4];
	assign gpio_pin_a_oe = ~m_q.c2[2];
	assign align_or_gpio_b_pin_o = m_q.c2[3];
	assign align_or_gpio_b_pin_oe = ~m_q.c2[1] & ~m_q.c2[0];
	assign align_pulse = m_q.pulse;

	// free path from the oscillator, outside any reset
	assign master_clock_inverted_output = mclk_out_en & ~aclk;

endmodule : adp_dev

// ---- rtl/adp_host.sv ----
// host controller: axi4-lite registers driving the serial link
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module adp_host
	import adp_pkg::*;
#(
	parameter int HALF = ADP_SCLK_HALF
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADP_AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADP_AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	adp_link_if.host link
);

	if (HALF < 2 || HALF > 255)
	begin : g_bad_half
		$error("half period must be 2 to 255");
	end

	typedef struct packed {
		adp_hst_t st;
		logic [7:0] cnt;
		logic [2:0] bitn;
		logic byte1;
		logic [1:0] tail;
		logic [7:0] sh;
		logic [7:0] rx;
		logic [7:0] rdata;
		logic done;
		logic [5:0] addr;
		logic rd;
		logic [7:0] wdat;
		logic framed;
		logic rst_on;
		logic d1;
		logic d2;
		logic sclk;
		logic cs_n;
		logic cs_oe;
		logic din;
		logic aw_ok;
		logic [ADP_AXI_AW-1:0] awa;
		logic w_ok;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [31:0] rdat;
		logic [1:0] rr;
	} adp_host_st_t;

	adp_host_st_t s_q;
	adp_host_st_t s_d;
	logic busy;
	logic last;
	logic [31:0] v;

	function automatic logic [31:0] adp_merge(
		input logic [31:0] o,
		input logic [31:0] n,
		input logic [3:0] s
	);
		for (int i = 0; i < 4; i++)
		begin
			if (s[i])
			begin
				o[8*i +: 8] = n[8*i +: 8];
			end
		end
		return o;
	endfunction : adp_merge

	assign busy = (s_q.st != ADP_IDLE) || s_q.rst_on || (s_q.tail != 2'h0);
	assign last = (s_q.cnt == 8'(HALF - 1));

	always_comb
	begin
		s_d = s_q;
		v = 32'h0;
		s_d.d1 = link.dout;
		s_d.d2 = s_q.d1;
		// write channels taken in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_d.aw_ok = 1'b1;
			s_d.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_d.w_ok = 1'b1;
			s_d.wd = s_axi_wdata;
			s_d.ws = s_axi_wstrb;
		end
		if (s_q.bv && s_axi_bready)
		begin
			s_d.bv = 1'b0;
		end
		if (s_q.aw_ok && s_q.w_ok)
		begin
			s_d.aw_ok = 1'b0;
			s_d.w_ok = 1'b0;
			s_d.bv = 1'b1;
			s_d.br = ADP_RESP_OKAY;
			case (s_q.awa)
				ADP_CMD_OFS:
				begin
					v = adp_merge({16'h0, s_q.wdat, 1'b0, s_q.rd, s_q.addr},
						s_q.wd, s_q.ws);
					if (busy)
					begin
						s_d.br = ADP_RESP_SLVERR;
					end
					else
					begin
						s_d.addr = v[5:0];
						s_d.rd = v[ADP_CMD_RW_BIT];
						s_d.wdat = v[ADP_CMD_WD_LSB +: 8];
						s_d.sh = {1'b0, v[ADP_CMD_RW_BIT], v[5:0]};
						s_d.byte1 = 1'b0;
						s_d.st = ADP_SEL;
					end
				end
				ADP_STAT_OFS:
				begin
					if (s_q.ws[0] && s_q.wd[ADP_STAT_DONE_BIT])
					begin
						s_d.done = 1'b0;
					end
				end
				ADP_CFG_OFS:
				begin
					v = adp_merge({30'h0, s_q.rst_on, s_q.framed},
						s_q.wd, s_q.ws);
					s_d.framed = v[ADP_CFG_FRAMED_BIT];
					s_d.rst_on = v[ADP_CFG_RST_BIT];
				end
				default:
				begin
					s_d.br = ADP_RESP_SLVERR;
				end
			endcase
		end
		if (s_q.rv && s_axi_rready)
		begin
			s_d.rv = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_d.rv = 1'b1;
			s_d.rr = ADP_RESP_OKAY;
			case (s_axi_araddr)
				ADP_CMD_OFS:
					s_d.rdat = {16'h0, s_q.wdat, 1'b0, s_q.rd, s_q.addr};
				ADP_STAT_OFS:
					s_d.rdat = {16'h0, s_q.rdata, 6'h0, s_q.done, busy};
				ADP_CFG_OFS:
					s_d.rdat = {30'h0, s_q.rst_on, s_q.framed};
				default:
				begin
					s_d.rdat = 32'h0;
					s_d.rr = ADP_RESP_SLVERR;
				end
			endcase
		end
		// serial engine
		case (s_q.st)
			ADP_IDLE:
			begin
				s_d.cs_oe = ~s_q.framed;
				s_d.cs_n = s_q.framed;
				if (s_q.rst_on)
				begin
					s_d.tail = ADP_RST_TAIL;
				end
				// clocks run during and after reset to flush device
				if (s_q.rst_on || s_q.tail != 2'h0)
				begin
					s_d.cnt = s_q.cnt + 8'h1;
					if (last)
					begin
						s_d.cnt = 8'h0;
						s_d.sclk = ~s_q.sclk;
						// count falls so the last high phase stays whole
						if (!s_q.rst_on && s_q.sclk)
						begin
							s_d.tail = s_q.tail - 2'h1;
						end
					end
				end
				else
				begin
					s_d.cnt = 8'h0;
					s_d.sclk = 1'b0;
				end
			end
			ADP_SEL:
			begin
				s_d.cs_oe = 1'b1;
				s_d.cs_n = 1'b0;
				s_d.din = s_q.sh[7];
				s_d.cnt = 8'h0;
				s_d.bitn = 3'h7;
				s_d.st = ADP_LOW;
			end
			ADP_LOW:
			begin
				s_d.cnt = s_q.cnt + 8'h1;
				if (last)
				begin
					s_d.cnt = 8'h0;
					s_d.rx = {s_q.rx[6:0], s_q.d2};
					s_d.sclk = 1'b1;
					s_d.st = ADP_HIGH;
				end
			end
			ADP_HIGH:
			begin
				s_d.cnt = s_q.cnt + 8'h1;
				if (last)
				begin
					s_d.cnt = 8'h0;
					s_d.sclk = 1'b0;
					if (s_q.bitn == 3'h0)
					begin
						s_d.st = ADP_GAP;
					end
					else
					begin
						s_d.bitn = s_q.bitn - 3'h1;
						s_d.sh = {s_q.sh[6:0], 1'b0};
						s_d.din = s_q.sh[6];
						s_d.st = ADP_LOW;
					end
				end
			end
			ADP_GAP:
			begin
				// framed mode raises select between bytes
				s_d.cs_n = s_q.framed;
				s_d.cnt = s_q.cnt + 8'h1;
				if (last)
				begin
					s_d.cnt = 8'h0;
					if (!s_q.byte1)
					begin
						s_d.byte1 = 1'b1;
						s_d.sh = s_q.rd ? 8'h00 : s_q.wdat;
						s_d.st = ADP_SEL;
					end
					else
					begin
						s_d.rdata = s_q.rx;
						s_d.done = 1'b1;
						s_d.st = ADP_IDLE;
					end
				end
			end
			default:
			begin
				s_d.st = ADP_IDLE;
			end
		endcase
		if (!aresetn)
		begin
			s_d = '0;
			s_d.st = ADP_IDLE;
			s_d.cs_n = 1'b1;
			s_d.framed = ADP_CFG_RST[ADP_CFG_FRAMED_BIT];
			s_d.rst_on = ADP_CFG_RST[ADP_CFG_RST_BIT];
		end
	end

	always_ff @(posedge aclk)
	begin
		s_q <= s_d;
	end

	assign s_axi_awready = ~s_q.aw_ok & ~s_q.bv;
	assign s_axi_wready = ~s_q.w_ok & ~s_q.bv;
	assign s_axi_bvalid = s_q.bv;
	assign s_axi_bresp = s_q.br;
	assign s_axi_arready = ~s_q.rv;
	assign s_axi_rvalid = s_q.rv;
	assign s_axi_rdata = s_q.rdat;
	assign s_axi_rresp = s_q.rr;
	assign link.sclk = s_q.sclk;
	assign link.cs_n_o = s_q.cs_n;
	assign link.cs_n_oe = s_q.cs_oe;
	assign link.din = s_q.din;
	assign link.rst_pin_n = ~s_q.rst_on;

endmodule : adp_host

// ---- bench/adp_chk.sv ----
// concurrent checks on the serial link between the two ends
`timescale 1ns/1ps
module adp_chk
	import adp_pkg::*;
#(
	parameter int HALF = ADP_SCLK_HALF
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sclk,
	input wire logic cs_n_o,
	input wire logic cs_n_oe,
	input wire logic cs_n,
	input wire logic din,
	input wire logic dout,
	input wire logic rst_pin_n
);
	logic prev_q;
	logic [7:0] run_q;
	logic [7:0] bits_q;
	// length of the current clock level, rises within a frame
	always_ff @(posedge aclk)
	begin
		prev_q <= sclk;
		if (!aresetn)
			run_q <= 8'h00;
		else if (sclk != prev_q)
			run_q <= 8'h01;
		else if (run_q != 8'hff)
			run_q <= run_q + 8'h01;
		if (cs_n)
			bits_q <= 8'h00;
		else
			bits_q <= bits_q + {7'h00, sclk & ~prev_q};
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence sel_lead;
		!sclk [*2];
	endsequence
	a_select_pullup: assert property (!cs_n_oe |-> cs_n)
		else $error("select not high when released");
	a_select_drive: assert property (cs_n_oe |-> cs_n == cs_n_o)
		else $error("select does not follow host drive");
	a_frame_lead: assert property ($fell(cs_n) |-> sel_lead)
		else $error("clock moved at frame start");
	a_byte_frame: assert property ($rose(cs_n) |-> bits_q[2:0] == 3'h0)
		else $error("frame not a whole byte");
	a_din_low_clock: assert property ($changed(din) |-> !sclk)
		else $error("data changed while clock high");
	a_high_len: assert property ($fell(sclk) |-> run_q == HALF)
		else $error("clock high phase wrong length");
	a_low_len: assert property ($rose(sclk) |-> run_q >= HALF)
		else $error("clock low phase too short");
	a_dout_on_rise: assert property ($changed(dout) |-> $rose(sclk))
		else $error("device data changed off clock rise");
	a_din_in_reset: assert property ($changed(din) |-> rst_pin_n)
		else $error("data moved while device held in reset");
endmodule : adp_chk

// ---- bench/tb_top.sv ----
// testbench: host and device joined over the serial link
`timescale 1ns/1ps
module tb_top
	import adp_pkg::*;
;
	logic aclk = 1'b0;
	logic mclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic mco_en = 1'b1;
	logic pa_x = 1'b1;
	logic pb_x = 1'b0;
	logic tw = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic pa_o, pa_oe, pb_o, pb_oe, pa, pb, mco, align;
	int fails = 0;
	int n_tests = 0;
	int n_al = 0;
	int cs_bad = 0;
	assign pa = pa_oe ? pa_o : pa_x;
	assign pb = pb_oe ? pb_o : pb_x;
	always #5 aclk = ~aclk;
	// master clock, phase kept off the host clock edges
	initial
	begin
		#3;
		forever #15 mclk = ~mclk;
	end
	always @(posedge mclk) if (align === 1'b1) n_al++;
	adp_link_if adp_link_if_i();
	adp_host adp_host_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.link(adp_link_if_i.host));
	adp_dev adp_dev_i (.aclk(mclk), .mclk_out_en(mco_en),
		.master_clock_inverted_output(mco), .link(adp_link_if_i.dev),
		.gpio_pin_a_i(pa), .gpio_pin_a_o(pa_o), .gpio_pin_a_oe(pa_oe),
		.align_or_gpio_b_pin_i(pb), .align_or_gpio_b_pin_o(pb_o),
		.align_or_gpio_b_pin_oe(pb_oe), .align_pulse(align));
	adp_chk adp_chk_i (.aclk(aclk), .aresetn(aresetn),
		.sclk(adp_link_if_i.sclk), .cs_n_o(adp_link_if_i.cs_n_o),
		.cs_n_oe(adp_link_if_i.cs_n_oe), .cs_n(adp_link_if_i.cs_n),
		.din(adp_link_if_i.din), .dout(adp_link_if_i.dout),
		.rst_pin_n(adp_link_if_i.rst_pin_n));
	always @(posedge aclk) if (tw && adp_link_if_i.cs_n !== 1'b0) cs_bad++;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic pend_a;
		logic pend_w;
		logic ka;
		logic kw;
		pend_a = 1'b1;
		pend_w = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pend_a || pend_w)
		begin
			@(negedge aclk);
			ka = pend_a && awready === 1'b1;
			kw = pend_w && wready === 1'b1;
			@(posedge aclk);
			if (ka)
				awvalid <= 1'b0;
			if (kw)
				wvalid <= 1'b0;
			pend_a = pend_a && !ka;
			pend_w = pend_w && !kw;
		end
		do @(negedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd
	// wait for the link transfer to finish, then clear done
	task automatic fin(output logic [7:0] q);
		logic [31:0] d;
		logic [1:0] r;
		do rd(ADP_STAT_OFS, d, r); while (d[ADP_STAT_DONE_BIT] !== 1'b1);
		q = d[15:8];
		wr(ADP_STAT_OFS, 32'h2, r);
	endtask : fin
	task automatic op(input logic rw, input logic [5:0] a,
		input logic [7:0] w, output logic [7:0] q);
		logic [1:0] r;
		wr(ADP_CMD_OFS, {16'h0, w, 1'b0, rw, a}, r);
		chk(32'(r), 32'(ADP_RESP_OKAY));
		fin(q);
	endtask : op
	task automatic cfg(input logic [1:0] v);
		logic [31:0] d;
		logic [1:0] r;
		wr(ADP_CFG_OFS, {30'h0, v}, r);
		do rd(ADP_STAT_OFS, d, r); while (d[ADP_STAT_BUSY_BIT] !== 1'b0);
	endtask : cfg
	task automatic wio(input logic [7:0] v);
		logic [7:0] q;
		op(1'b0, ADP_IO_ADDR, v, q);
	endtask : wio
	task automatic rio(input logic [7:0] e);
		logic [7:0] q;
		op(1'b1, ADP_IO_ADDR, 8'h00, q);
		chk(32'(q), 32'(e));
	endtask : rio
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	// over twenty times the expected run length
	initial
	begin
		#400000;
		fails++;
		conclude();
	end
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] q;
		int n0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADP_CFG_OFS, d, r);
		chk(d, {30'h0, ADP_CFG_RST});
		chk(32'(r), 32'(ADP_RESP_OKAY));
		rd(8'h0c, d, r);
		chk({d[29:0], r}, {30'h0, ADP_RESP_SLVERR});
		wr(8'h0c, 32'h1, r);
		chk(32'(r), 32'(ADP_RESP_SLVERR));
		$display("end host registers");
		cfg(2'h1);
		rio(8'hb0);
		wio(8'h3e);
		rio(8'hb8);
		pa_x <= 1'b0;
		wio(8'h90);
		chk(32'({pa_oe, pa_o}), 32'h3);
		rio(8'h90);
		wio(8'h40);
		chk(32'({pb_oe, pb_o, pa_o}), 32'h6);
		rio(8'h40);
		$display("end pin directions");
		pb_x <= 1'b1;
		wio(8'h31);
		repeat (20) @(posedge aclk);
		n0 = n_al;
		pb_x <= 1'b0;
		repeat (40) @(posedge aclk);
		chk(32'(n_al - n0), 32'h1);
		chk(32'(pb_oe), 32'h0);
		$display("end align");
		wr(ADP_CMD_OFS, 32'h00003001, r);
		chk(32'(r), 32'(ADP_RESP_OKAY));
		wr(ADP_CMD_OFS, 32'h00003001, r);
		chk(32'(r), 32'(ADP_RESP_SLVERR));
		fin(q);
		rio(8'h30);
		op(1'b0, 6'h02, 8'h5a, q);
		op(1'b1, 6'h02, 8'h00, q);
		chk(32'(q), 32'h0);
		$display("end routing");
		cfg(2'h0);
		tw <= 1'b1;
		wio(8'h00);
		rio(8'h00);
		tw <= 1'b0;
		chk(32'(cs_bad), 32'h0);
		$display("end three-wire");
		wr(ADP_CFG_OFS, 32'h3, r);
		chk(32'(r), 32'(ADP_RESP_OKAY));
		repeat (20) @(posedge aclk);
		chk(32'({pa_oe, pb_oe}), 32'h0);
		@(posedge mclk);
		#1 chk(32'(mco), 32'h0);
		@(negedge mclk);
		#1 chk(32'(mco), 32'h1);
		@(posedge aclk);
		mco_en <= 1'b0;
		@(negedge mclk);
		#1 chk(32'(mco), 32'h0);
		cfg(2'h1);
		rio(8'h30);
		$display("end device reset");
		conclude();
	end
endmodule : tb_top
